// File: bench/scr_ctrl_model.sv
/*
  Controller model for the stepper control register bank: issues decoded
  register writes and reads one at a time on clk.
  Assumes the bench calls wr and rd and owns all other design inputs.
*/
`timescale 1ns/100ps
module scr_ctrl_model (
  input  wire logic        clk,
  input  wire logic [7:0]  reg_rdata,
  output scr_pkg::scr_wr_t reg_wr,
  output logic             reg_rd,
  output logic [5:0]       reg_rd_addr
);
  import scr_pkg::*;

  // Idle bus from time zero
  initial begin
    reg_wr      = '0;
    reg_rd      = 1'b0;
    reg_rd_addr = 6'h00;
  end

  // One write, valid for exactly one edge; the model sanitises its own data
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == SCR_ADDR_STALL) v = d & 8'h38;  // Reserved stall bits go out as zero
    if (a == SCR_ADDR_STEP && d[3:0] > 4'ha) v[3:0] = SCR_USTEP_RST;  // No reserved code
    @(posedge clk);
    reg_wr <= '{valid: 1'b1, addr: a, data: v};
    @(posedge clk);
    reg_wr.valid <= 1'b0;
  endtask

  // One read; data is taken after the edge that follows the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd      <= 1'b1;
    reg_rd_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// File: bench/stepper_control_register_bank_tb.sv
/*
  Self-checking testbench for the stepper control register bank.
  Assumes scr_pkg, scr_bank and the controller model are compiled first.
*/
`timescale 1ns/100ps
module stepper_control_register_bank_tb;
  import scr_pkg::*;
  logic       clk, rst, dir_pin, step_pin, done, ok, reg_rd;
  logic       step_pulse, step_dir, fault_clear_pulse, stall_learn_start;
  logic       stall_learn_success_flag, config_locked;
  logic [5:0] reg_rd_addr;
  logic [7:0] reg_rdata;
  scr_wr_t    reg_wr;
  scr_cfg_t   cfg;
  int         n_fail, n_tests;

  scr_bank u_dut (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_addr(reg_rd_addr),
    .reg_rdata(reg_rdata), .dir_pin(dir_pin), .step_pin(step_pin),
    .stall_learn_done(done), .stall_learn_ok(ok), .step_pulse(step_pulse),
    .step_dir(step_dir), .cfg(cfg), .fault_clear_pulse(fault_clear_pulse),
    .stall_learn_start(stall_learn_start),
    .stall_learn_success_flag(stall_learn_success_flag), .config_locked(config_locked)
  );
  scr_ctrl_model u_ctrl (
    .clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rd_addr(reg_rd_addr)
  );

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_ctrl.rd(a, d);
    chk(d, exp);
  endtask

  // Step past the next edge and let its updates settle
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // Raise the step pin for a few cycles and count the pulses it causes
  task automatic pin_step(output logic [7:0] n);
    n = 0;
    @(posedge clk) step_pin <= 1'b1;
    repeat (4) begin tick(); n += step_pulse; end
    @(posedge clk) step_pin <= 1'b0;
    repeat (4) begin tick(); n += step_pulse; end
  endtask

  task automatic t_reset();
    chk(cfg, SCR_CFG_RST);
    chk({config_locked, step_pulse, stall_learn_start}, 3'h0);
    rdchk(SCR_ADDR_STEP, 8'h06);
    rdchk(SCR_ADDR_FAULT, 8'h30);
    rdchk(SCR_ADDR_STALL, 8'h08);
    rdchk(SCR_ADDR_DIAG2, 8'h00);
    rdchk(6'h10, SCR_RDATA_UNMAP);
  endtask

  // Register step and direction, then the same with direction zero
  task automatic t_reg_step();
    u_ctrl.wr(SCR_ADDR_STEP, 8'hfa);
    #1 chk(step_pulse, 1'b1);
    tick();
    chk(step_pulse, 1'b0);
    chk(step_dir, 1'b1);
    chk(cfg.microstep_mode, 4'ha);
    rdchk(SCR_ADDR_STEP, 8'hba);
    u_ctrl.wr(SCR_ADDR_STEP, 8'h7a);
    #1 chk(step_pulse, 1'b1);
    tick();
    tick();
    chk(step_dir, 1'b0);
  endtask

  // Pin stepping, then pin edges ignored under register stepping
  task automatic t_pin_step();
    logic [7:0] n;
    u_ctrl.wr(SCR_ADDR_STEP, 8'h06);
    @(posedge clk) dir_pin <= 1'b1;
    repeat (5) tick();
    chk(step_dir, 1'b1);
    pin_step(n);
    chk(n, 1);
    u_ctrl.wr(SCR_ADDR_STEP, 8'h16);
    pin_step(n);
    chk(n, 0);
  endtask

  // Every defined resolution code, stored and read back
  task automatic t_ustep();
    for (int c = 0; c <= 10; c++) begin
      u_ctrl.wr(SCR_ADDR_STEP, c[7:0]);
      tick();
      chk(cfg.microstep_mode, c[3:0]);
      rdchk(SCR_ADDR_STEP, c[7:0]);
    end
  endtask

  task automatic t_fault();
    u_ctrl.wr(SCR_ADDR_FAULT, 8'hdf);
    #1 chk(fault_clear_pulse, 1'b1);
    tick();
    chk(fault_clear_pulse, 1'b0);
    chk(config_locked, 1'b0);
    chk(cfg[5:2], 4'hf);
    rdchk(SCR_ADDR_FAULT, 8'h3f);
    u_ctrl.wr(SCR_ADDR_FAULT, 8'h35);
    tick();
    chk(cfg[5:2], 4'h5);
  endtask

  task automatic t_stall();
    u_ctrl.wr(SCR_ADDR_STALL, 8'h38);
    #1 chk(stall_learn_start, 1'b1);
    rdchk(SCR_ADDR_STALL, 8'h38);
    chk(cfg[1:0], 2'h3);
    @(posedge clk) begin done <= 1'b1; ok <= 1'b1; end
    @(posedge clk) done <= 1'b0;
    #1 chk(stall_learn_start, 1'b0);
    chk(stall_learn_success_flag, 1'b1);
    rdchk(SCR_ADDR_DIAG2, 8'h10);
    u_ctrl.wr(SCR_ADDR_STALL, 8'h00);
    tick();
    chk(cfg[1:0], 2'h0);
  endtask

  // Lock, refused writes, clear still acting, wrong unlock code, unlock
  task automatic t_lock();
    u_ctrl.wr(SCR_ADDR_FAULT, 8'h60);
    tick();
    tick();
    chk(config_locked, 1'b1);
    u_ctrl.wr(SCR_ADDR_STEP, 8'h50);
    #1 chk(step_pulse, 1'b0);
    rdchk(SCR_ADDR_STEP, 8'h0a);
    u_ctrl.wr(SCR_ADDR_STALL, 8'h38);
    tick();
    chk(stall_learn_start, 1'b0);
    chk(cfg[1:0], 2'h0);
    u_ctrl.wr(SCR_ADDR_FAULT, 8'he5);
    #1 chk(fault_clear_pulse, 1'b1);
    u_ctrl.wr(SCR_ADDR_FAULT, 8'h10);
    rdchk(SCR_ADDR_FAULT, 8'h60);
    u_ctrl.wr(SCR_ADDR_FAULT, 8'h30);
    tick();
    tick();
    chk(config_locked, 1'b0);
    u_ctrl.wr(SCR_ADDR_STEP, 8'h05);
    rdchk(SCR_ADDR_STEP, 8'h05);
  endtask

  // Failed learning leaves the flag low; a mid-run reset restores defaults
  task automatic t_fail_reset();
    u_ctrl.wr(SCR_ADDR_STALL, 8'h20);
    #1 chk(stall_learn_success_flag, 1'b0);
    @(posedge clk) begin done <= 1'b1; ok <= 1'b0; end
    @(posedge clk) done <= 1'b0;
    #1 chk({stall_learn_start, stall_learn_success_flag}, 2'h0);
    u_ctrl.wr(SCR_ADDR_FAULT, 8'h6f);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk(cfg, SCR_CFG_RST);
    chk(config_locked, 1'b0);
    rdchk(SCR_ADDR_FAULT, 8'h30);
    rdchk(SCR_ADDR_STEP, 8'h06);
  endtask

  // Main sequence
  initial begin
    n_fail   = 0;
    n_tests  = 0;
    rst      = 1'b1;
    dir_pin  = 1'b0;
    step_pin = 1'b0;
    done     = 1'b0;
    ok       = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_reg_step();
    t_pin_step();
    t_ustep();
    t_fault();
    t_stall();
    t_lock();
    t_fail_reset();
    give_verdict();
  end

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule

// File: hw/scr_bank.sv
/*
  Stepper control register bank: step control, fault and lock control,
  stall control, plus the learn success status flag.
  Assumes reg_wr and reg_rd come from a serial framer on clk, one cycle
  each; dir_pin and step_pin are raw pins; learn handshake is on clk.
*/
`timescale 1ns/100ps

module scr_bank (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire scr_pkg::scr_wr_t  reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [5:0]        reg_rd_addr,
  output logic      [7:0]        reg_rdata,
  input  wire logic              dir_pin,
  input  wire logic              step_pin,
  input  wire logic              stall_learn_done,
  input  wire logic              stall_learn_ok,
  output logic                   step_pulse,
  output logic                   step_dir,
  output scr_pkg::scr_cfg_t      cfg,
  output logic                   fault_clear_pulse,
  output logic                   stall_learn_start,
  output logic                   stall_learn_success_flag,
  output logic                   config_locked
);
  import scr_pkg::*;

  logic       dir_bit_reg;
  logic       dir_src_reg;
  logic       step_src_reg;
  logic [2:0] lock_reg;
  logic       dir_meta_reg;
  logic       dir_sync_reg;
  logic       step_meta_reg;
  logic       step_sync_reg;
  logic       step_prev_reg;
  logic       locked;
  logic       wr_step;
  logic       wr_fault;
  logic       wr_stall;
  logic [2:0] wr_lock;
  logic       reg_step_ev;
  logic       pin_step_ev;
  logic       learn_begin;

  // Write decode, shared by every register
  function automatic logic wr_hit(input scr_wr_t w, input logic [5:0] a);
    wr_hit = w.valid && (w.addr == a);
  endfunction

  assign locked   = (lock_reg == SCR_LOCK_ON);
  assign wr_step  = wr_hit(reg_wr, SCR_ADDR_STEP) && !locked;
  assign wr_fault = wr_hit(reg_wr, SCR_ADDR_FAULT);
  assign wr_stall = wr_hit(reg_wr, SCR_ADDR_STALL) && !locked;
  assign wr_lock  = reg_wr.data[SCR_LOCK_MSB:SCR_LOCK_LSB];

  // Register step takes effect with the source bit of the same write
  assign reg_step_ev = wr_step && reg_wr.data[SCR_STEP_BIT]
                       && reg_wr.data[SCR_STEPSRC_BIT];
  assign pin_step_ev = !step_src_reg && step_sync_reg && !step_prev_reg;
  assign learn_begin = wr_stall && reg_wr.data[SCR_LEARN_BIT];

  // Pin synchronisers; logic reads the second stage, and the step edge detect also reads the third
  always_ff @(posedge clk) begin
    if (rst) begin
      dir_meta_reg  <= 1'b0;
      dir_sync_reg  <= 1'b0;
      step_meta_reg <= 1'b0;
      step_sync_reg <= 1'b0;
      step_prev_reg <= 1'b0;
    end else begin
      dir_meta_reg  <= dir_pin;
      dir_sync_reg  <= dir_meta_reg;
      step_meta_reg <= step_pin;
      step_sync_reg <= step_meta_reg;
      step_prev_reg <= step_sync_reg;
    end
  end

  // Step control register; the step bit itself is never stored
  always_ff @(posedge clk) begin
    if (rst) begin
      dir_bit_reg        <= 1'b0;
      dir_src_reg        <= 1'b0;
      step_src_reg       <= 1'b0;
      cfg.microstep_mode <= SCR_USTEP_RST;
    end else if (wr_step) begin
      dir_bit_reg        <= reg_wr.data[SCR_DIR_BIT];
      dir_src_reg        <= reg_wr.data[SCR_DIRSRC_BIT];
      step_src_reg       <= reg_wr.data[SCR_STEPSRC_BIT];
      cfg.microstep_mode <= reg_wr.data[SCR_USTEP_MSB:0];
    end
  end

  // Direction mux is registered so the output comes from a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      step_dir <= 1'b0;
    end else begin
      step_dir <= dir_src_reg ? dir_bit_reg : dir_sync_reg;
    end
  end

  // Pulse for any accepted step from either source; a register step and a pin step in the same cycle share one pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      step_pulse <= 1'b0;
    end else begin
      step_pulse <= reg_step_ev || pin_step_ev;
    end
  end

  // Lock field: only the two legal transitions are honoured
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_reg <= SCR_LOCK_RST;
    end else if (wr_fault) begin
      if (!locked && wr_lock == SCR_LOCK_ON) begin
        lock_reg <= SCR_LOCK_ON;
      end else if (locked && wr_lock == SCR_LOCK_OFF) begin
        lock_reg <= SCR_LOCK_OFF;
      end
    end
  end

  // Lock state seen outside, one cycle behind the internal decode
  always_ff @(posedge clk) begin
    if (rst) begin
      config_locked <= 1'b0;
    end else begin
      config_locked <= locked;
    end
  end

  // Fault clear acts even while locked and lasts one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_clear_pulse <= 1'b0;
    end else begin
      fault_clear_pulse <= wr_fault && reg_wr.data[SCR_CLR_BIT];
    end
  end

  // Protection behaviour fields, frozen while locked
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg.open_load_enable                  <= SCR_CFG_RST.open_load_enable;
      cfg.overcurrent_behaviour_select      <= SCR_CFG_RST.overcurrent_behaviour_select;
      cfg.thermal_shutdown_behaviour_select <= SCR_CFG_RST.thermal_shutdown_behaviour_select;
      cfg.thermal_warning_report            <= SCR_CFG_RST.thermal_warning_report;
    end else if (wr_fault && !locked) begin
      cfg.open_load_enable                  <= reg_wr.data[SCR_OL_BIT];
      cfg.overcurrent_behaviour_select      <= reg_wr.data[SCR_OCP_BIT];
      cfg.thermal_shutdown_behaviour_select <= reg_wr.data[SCR_OTSD_BIT];
      cfg.thermal_warning_report            <= reg_wr.data[SCR_TWREP_BIT];
    end
  end

  // Stall enable and report; reserved bits are not kept
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg.stall_detect_enable <= SCR_CFG_RST.stall_detect_enable;
      cfg.stall_report_enable <= SCR_CFG_RST.stall_report_enable;
    end else if (wr_stall) begin
      cfg.stall_detect_enable <= reg_wr.data[SCR_STLEN_BIT];
      cfg.stall_report_enable <= reg_wr.data[SCR_STLREP_BIT];
    end
  end

  // Learn bit holds until the learner reports done; a new start wins
  always_ff @(posedge clk) begin
    if (rst) begin
      stall_learn_start <= 1'b0;
    end else if (learn_begin) begin
      stall_learn_start <= 1'b1;
    end else if (stall_learn_done) begin
      stall_learn_start <= 1'b0;
    end
  end

  // Success flag: set on good completion, dropped by a new start; a good completion in the same cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      stall_learn_success_flag <= 1'b0;
    end else if (stall_learn_start && stall_learn_done && stall_learn_ok) begin
      stall_learn_success_flag <= 1'b1;
    end else if (learn_begin) begin
      stall_learn_success_flag <= 1'b0;
    end
  end

  // Read data is captured on the read strobe, unmapped reads give zero
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= SCR_RDATA_UNMAP;
    end else if (reg_rd) begin
      unique case (reg_rd_addr)
        SCR_ADDR_STEP:
          reg_rdata <= {dir_bit_reg, 1'b0, dir_src_reg, step_src_reg,
                        cfg.microstep_mode};
        SCR_ADDR_FAULT:
          reg_rdata <= {1'b0, lock_reg, cfg.open_load_enable,
                        cfg.overcurrent_behaviour_select,
                        cfg.thermal_shutdown_behaviour_select,
                        cfg.thermal_warning_report};
        SCR_ADDR_STALL:
          reg_rdata <= {2'h0, stall_learn_start, cfg.stall_detect_enable,
                        cfg.stall_report_enable, 3'h0};
        SCR_ADDR_DIAG2:
          reg_rdata <= {3'h0, stall_learn_success_flag, 4'h0};
        default:
          reg_rdata <= SCR_RDATA_UNMAP;
      endcase
    end
  end

  // Checks next to the logic they guard; the field write checks compare against the bus
  // word of the cycle before, so a wrongly routed field still shows up
  a_reg_step_pulse: assert property (@(posedge clk) disable iff (rst)
    reg_step_ev |=> step_pulse ##1 (step_pulse == $past(reg_step_ev || pin_step_ev)))
    else $error("register step did not give one pulse");

  a_step_reads_zero: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && reg_rd_addr == SCR_ADDR_STEP) |=> !reg_rdata[SCR_STEP_BIT])
    else $error("step bit read back as one");

  a_dir_from_reg: assert property (@(posedge clk) disable iff (rst)
    dir_src_reg |=> step_dir == $past(dir_bit_reg))
    else $error("direction not taken from register");

  a_dir_from_pin: assert property (@(posedge clk) disable iff (rst)
    !dir_src_reg |=> step_dir == $past(dir_sync_reg))
    else $error("direction not taken from pin");

  a_dir_bit_write: assert property (@(posedge clk) disable iff (rst)
    wr_step |=> dir_bit_reg == $past(reg_wr.data[SCR_DIR_BIT]))
    else $error("direction bit not written");

  a_src_write: assert property (@(posedge clk) disable iff (rst)
    wr_step |=> (dir_src_reg == $past(reg_wr.data[SCR_DIRSRC_BIT]))
                && (step_src_reg == $past(reg_wr.data[SCR_STEPSRC_BIT])))
    else $error("source select bits not written");

  a_ustep_write: assert property (@(posedge clk) disable iff (rst)
    wr_step |=> cfg.microstep_mode == $past(reg_wr.data[SCR_USTEP_MSB:0]))
    else $error("microstep field not written");

  a_pin_step_edge: assert property (@(posedge clk) disable iff (rst)
    (!step_src_reg && $rose(step_sync_reg)) |=> step_pulse)
    else $error("pin edge gave no step");

  a_pin_step_ignored: assert property (@(posedge clk) disable iff (rst)
    (step_src_reg && !reg_step_ev) |=> !step_pulse)
    else $error("step while pin source deselected");

  a_fault_clear_one: assert property (@(posedge clk) disable iff (rst)
    (wr_fault && reg_wr.data[SCR_CLR_BIT]) ##1 !(wr_fault && reg_wr.data[SCR_CLR_BIT])
    |-> fault_clear_pulse ##1 !fault_clear_pulse)
    else $error("fault clear pulse wrong length");

  a_clear_idle: assert property (@(posedge clk) disable iff (rst)
    !(wr_fault && reg_wr.data[SCR_CLR_BIT]) |=> !fault_clear_pulse)
    else $error("fault clear pulse without a write");

  a_clear_when_locked: assert property (@(posedge clk) disable iff (rst)
    (locked && wr_fault && reg_wr.data[SCR_CLR_BIT]) |=> fault_clear_pulse)
    else $error("fault clear refused while locked");

  a_lock_takes: assert property (@(posedge clk) disable iff (rst)
    (wr_fault && !locked && wr_lock == SCR_LOCK_ON) |=> locked ##1 config_locked)
    else $error("lock code did not lock");

  a_locked_frozen: assert property (@(posedge clk) disable iff (rst)
    (locked && !wr_fault) |=> $stable(cfg) && $stable(dir_src_reg) && $stable(step_src_reg))
    else $error("configuration changed while locked");

  a_locked_no_step: assert property (@(posedge clk) disable iff (rst)
    (locked && !pin_step_ev) |=> !step_pulse)
    else $error("register step acted while locked");

  a_locked_no_learn: assert property (@(posedge clk) disable iff (rst)
    (locked && !stall_learn_start) |=> !stall_learn_start)
    else $error("learning started while locked");

  a_unlock_other: assert property (@(posedge clk) disable iff (rst)
    (wr_fault && !locked && wr_lock != SCR_LOCK_ON) |=> !locked)
    else $error("non-lock code locked the bank");

  a_unlock_code: assert property (@(posedge clk) disable iff (rst)
    (wr_fault && locked) |=> (locked == ($past(wr_lock) != SCR_LOCK_OFF)))
    else $error("lock state wrong after locked write");

  a_fault_cfg_write: assert property (@(posedge clk) disable iff (rst)
    (wr_fault && !locked) |=>
      {cfg.open_load_enable, cfg.overcurrent_behaviour_select,
       cfg.thermal_shutdown_behaviour_select, cfg.thermal_warning_report}
      == $past(reg_wr.data[SCR_OL_BIT:SCR_TWREP_BIT]))
    else $error("protection fields not written");

  a_stall_fields: assert property (@(posedge clk) disable iff (rst)
    wr_stall |=> {cfg.stall_detect_enable, cfg.stall_report_enable}
                 == $past(reg_wr.data[SCR_STLEN_BIT:SCR_STLREP_BIT]))
    else $error("stall fields not written");

  a_reset_values: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> (cfg == SCR_CFG_RST) && !locked && !stall_learn_start)
    else $error("wrong value after reset");

  a_learn_starts: assert property (@(posedge clk) disable iff (rst)
    learn_begin |=> stall_learn_start)
    else $error("learn bit not set by write");

  a_learn_ends: assert property (@(posedge clk) disable iff (rst)
    (stall_learn_start && stall_learn_done && !learn_begin) |=> !stall_learn_start)
    else $error("learn bit did not return to zero");

  a_learn_ok_flag: assert property (@(posedge clk) disable iff (rst)
    (stall_learn_start && stall_learn_done && stall_learn_ok) |=>
      stall_learn_success_flag ##1 (stall_learn_success_flag || $past(learn_begin)))
    else $error("learn success not flagged");

  a_learn_fail_flag: assert property (@(posedge clk) disable iff (rst)
    (learn_begin && !(stall_learn_start && stall_learn_done && stall_learn_ok))
    |=> !stall_learn_success_flag)
    else $error("learn success flag kept over a new start");

endmodule

// File: hw/scr_pkg.sv
/*
  Constants and carrier types for the stepper control register bank:
  register addresses, field positions, reset values and lock codes.
  Assumes the serial framer delivers whole decoded register accesses.
*/
package scr_pkg;

  // Register addresses on the serial register interface
  localparam logic [5:0] SCR_ADDR_DIAG2 = 6'h02;
  localparam logic [5:0] SCR_ADDR_STEP  = 6'h05;
  localparam logic [5:0] SCR_ADDR_FAULT = 6'h06;
  localparam logic [5:0] SCR_ADDR_STALL = 6'h07;

  // Step control fields
  localparam int SCR_DIR_BIT      = 7;
  localparam int SCR_STEP_BIT     = 6;
  localparam int SCR_DIRSRC_BIT   = 5;
  localparam int SCR_STEPSRC_BIT  = 4;
  localparam int SCR_USTEP_MSB    = 3;

  // Fault and lock control fields
  localparam int SCR_CLR_BIT      = 7;
  localparam int SCR_LOCK_MSB     = 6;
  localparam int SCR_LOCK_LSB     = 4;
  localparam int SCR_OL_BIT       = 3;
  localparam int SCR_OCP_BIT      = 2;
  localparam int SCR_OTSD_BIT     = 1;
  localparam int SCR_TWREP_BIT    = 0;

  // Stall control fields and status flag position
  localparam int SCR_LEARN_BIT    = 5;
  localparam int SCR_STLEN_BIT    = 4;
  localparam int SCR_STLREP_BIT   = 3;
  localparam int SCR_LEARNOK_BIT  = 4;

  // Reset values and lock codes
  localparam logic [3:0] SCR_USTEP_RST    = 4'h6;
  localparam logic [2:0] SCR_LOCK_ON      = 3'h6;
  localparam logic [2:0] SCR_LOCK_OFF     = 3'h3;
  localparam logic [2:0] SCR_LOCK_RST     = 3'h3;
  localparam logic       SCR_STLREP_RST   = 1'b1;
  localparam logic [7:0] SCR_RDATA_UNMAP  = 8'h00;

  // Configuration handed to the driver core
  typedef struct packed {
    logic [3:0] microstep_mode;
    logic       open_load_enable;
    logic       overcurrent_behaviour_select;
    logic       thermal_shutdown_behaviour_select;
    logic       thermal_warning_report;
    logic       stall_detect_enable;
    logic       stall_report_enable;
  } scr_cfg_t;

  localparam scr_cfg_t SCR_CFG_RST = '{
    microstep_mode:                    SCR_USTEP_RST,
    open_load_enable:                  1'b0,
    overcurrent_behaviour_select:      1'b0,
    thermal_shutdown_behaviour_select: 1'b0,
    thermal_warning_report:            1'b0,
    stall_detect_enable:               1'b0,
    stall_report_enable:               SCR_STLREP_RST
  };

  // One decoded register write from the serial framer
  typedef struct packed {
    logic       valid;
    logic [5:0] addr;
    logic [7:0] data;
  } scr_wr_t;

endpackage
